/* File: include/nrs_pkg.sv */
// constants and types of the nand read/program command sequencer
// assumes one 200 MHz clock and a nand target with an active-high ready line
package nrs_pkg;
  // sequence pattern numbers
  localparam logic [4:0] PATTERN_SEVEN = 5'h07;
  localparam logic [4:0] PATTERN_EIGHT = 5'h08;
  localparam logic [4:0] PATTERN_NINE = 5'h09;
  localparam logic [4:0] PATTERN_TEN = 5'h0A;
  localparam logic [4:0] PATTERN_ELEVEN = 5'h0B;
  localparam logic [4:0] PATTERN_TWELVE = 5'h0C;
  localparam logic [4:0] PATTERN_FIFTEEN = 5'h0F;
  localparam logic [4:0] PATTERN_TWENTY_TWO = 5'h16;
  localparam logic [4:0] PATTERN_TWENTY_THREE = 5'h17;
  // opcodes
  localparam logic [7:0] OP_SELECT_CACHE = 8'h06;
  localparam logic [7:0] OP_READ_START = 8'h00;
  localparam logic [7:0] OP_CLOSE_E0 = 8'hE0;
  localparam logic [7:0] OP_CHANGE_WRITE = 8'h85;
  localparam logic [7:0] OP_MULTIPLANE_Q = 8'h11;
  localparam logic [7:0] OP_READ_CONFIRM = 8'h30;
  localparam logic [7:0] OP_CACHE_SEQ = 8'h31;
  localparam logic [7:0] OP_CACHE_LAST = 8'h3F;
  localparam logic [7:0] OP_READ_MULTI = 8'h32;
  localparam logic [7:0] OP_QUEUE_READ = 8'h07;
  localparam logic [7:0] OP_QUEUE_CONFIRM = 8'h37;
  localparam logic [7:0] OP_PROGRAM = 8'h80;
  localparam logic [7:0] OP_PROGRAM_GO = 8'h10;
  // address cycle counts and the byte count reset value
  localparam logic [2:0] ADDR_COLUMN_ONLY = 3'd2;
  localparam logic [2:0] ADDR_ROW_ONLY = 3'd3;
  localparam logic [2:0] ADDR_FULL = 3'd5;
  localparam logic [2:0] ADDR_QUEUE = 3'd7;
  localparam logic [15:0] LENGTH_RESET = 16'h0000;
  // bus cycle kinds and sequencer states
  typedef enum logic [1:0] {NRS_CYC_CMD, NRS_CYC_ADDR, NRS_CYC_WDATA, NRS_CYC_RDATA} nrs_cyc_t;
  typedef enum logic [3:0] {
    NRS_IDLE, NRS_OP0, NRS_ADDR, NRS_OP1, NRS_WRITE, NRS_OP2, NRS_BUSY_WAIT, NRS_READ, NRS_DONE
  } nrs_state_t;
endpackage

/* File: src/nrs_cycle_unit.sv */
// one nand bus cycle at a time: command, address or data byte
// assumes the pin timing logic downstream accepts a cycle with cyc_ready
`timescale 1ns/1ps
`default_nettype none
module nrs_cycle_unit
  import nrs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire nrs_pkg::nrs_cyc_t issue_kind,
  input wire logic [7:0] issue_byte,
  output logic cyc_valid,
  input wire logic cyc_ready,
  output nrs_pkg::nrs_cyc_t cyc_kind,
  output logic [7:0] cyc_byte
);
  typedef struct packed {
    logic valid;
    nrs_cyc_t kind;
    logic [7:0] data;
  } nrs_cu_t;
  nrs_cu_t st, next_st;

  always_comb
  begin
    next_st = st;
    if (st.valid && cyc_ready)
    begin
      next_st.valid = 1'b0;
    end
    if (issue_valid && issue_ready)
    begin
      next_st.valid = 1'b1;
      next_st.kind = issue_kind;
      next_st.data = issue_byte;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{valid: 1'b0, kind: NRS_CYC_CMD, data: 8'h00};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign issue_ready = !st.valid || cyc_ready;
  assign cyc_valid = st.valid;
  assign cyc_kind = st.kind;
  assign cyc_byte = st.data;
endmodule
`default_nettype wire

/* File: src/nrs_sequencer.sv */
// command sequencer: turns one instruction into nand command, address and data cycles
// assumes an active-high ready line already synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module nrs_sequencer
  import nrs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic start,
  output logic start_ready,
  input wire logic [4:0] sequence_pattern_field,
  input wire logic [7:0] opcode0,
  input wire logic [7:0] opcode1,
  input wire logic [7:0] opcode2,
  input wire logic data_sel,
  input wire logic [39:0] first_address_register,
  input wire logic [39:0] second_address_register,
  input wire logic [15:0] byte_count,
  input wire logic target_ready,
  output logic busy,
  output logic done,
  output logic cmd_error,
  output logic cyc_valid,
  input wire logic cyc_ready,
  output nrs_pkg::nrs_cyc_t cyc_kind,
  output logic [7:0] cyc_byte,
  input wire logic [7:0] wdata,
  input wire logic wdata_valid,
  output logic wdata_ready,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  output logic [7:0] fifo_data,
  output logic fifo_valid,
  input wire logic fifo_ready,
  output logic [7:0] data_register
);
  import nrs_pkg::*;

  typedef struct packed {
    nrs_state_t state;
    logic [4:0] pattern;
    logic [7:0] op0;
    logic [7:0] op1;
    logic [7:0] op2;
    logic to_data_reg;
    logic [2:0] addr_len;
    logic [2:0] addr_idx;
    logic [55:0] addr_bytes;
    logic [15:0] count;
    logic [15:0] remain;
    logic has_write;
    logic has_read;
    logic has_op1;
    logic has_op2;
    logic second_addr;
    logic [7:0] fifo_byte;
    logic fifo_full;
    logic rd_wait;
    logic [7:0] dreg;
    logic done;
    logic err;
  } nrs_seq_t;
  nrs_seq_t st, next_st;

  logic issue_valid;
  logic issue_ready;
  nrs_cyc_t issue_kind;
  logic [7:0] issue_byte;
  logic pattern_ok;

  always_comb
  begin
    pattern_ok = 1'b1;
    unique case (sequence_pattern_field)
      PATTERN_SEVEN, PATTERN_EIGHT, PATTERN_NINE, PATTERN_TEN, PATTERN_ELEVEN,
      PATTERN_TWELVE, PATTERN_FIFTEEN, PATTERN_TWENTY_TWO, PATTERN_TWENTY_THREE:
        pattern_ok = 1'b1;
      default:
        pattern_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    issue_valid = 1'b0;
    issue_kind = NRS_CYC_CMD;
    issue_byte = 8'h00;
    wdata_ready = 1'b0;
    if (st.fifo_full && fifo_ready)
    begin
      next_st.fifo_full = 1'b0;
    end
    unique case (st.state)
      NRS_IDLE:
      begin
        // a ready target is required before any command is taken
        if (start && target_ready)
        begin
          next_st.err = !pattern_ok;
          next_st.pattern = sequence_pattern_field;
          next_st.op0 = opcode0;
          next_st.op1 = opcode1;
          next_st.op2 = opcode2;
          next_st.to_data_reg = data_sel;
          next_st.addr_idx = 3'd0;
          next_st.second_addr = 1'b0;
          next_st.count = byte_count;
          next_st.has_write = 1'b0;
          next_st.has_read = data_sel;
          next_st.has_op1 = 1'b0;
          next_st.has_op2 = 1'b0;
          next_st.addr_len = ADDR_FULL;
          next_st.addr_bytes = {16'h0000, first_address_register};
          next_st.state = pattern_ok ? NRS_OP0 : NRS_DONE;
          unique case (sequence_pattern_field)
            PATTERN_SEVEN:
            begin
              next_st.has_op2 = 1'b1;
            end
            PATTERN_EIGHT:
            begin
              next_st.addr_len = ADDR_COLUMN_ONLY;
              next_st.has_read = 1'b0;
            end
            PATTERN_NINE:
            begin
              next_st.has_op1 = 1'b1;
              next_st.has_read = 1'b0;
            end
            PATTERN_TEN:
            begin
              next_st.has_op2 = 1'b1;
              next_st.has_read = 1'b1;
            end
            PATTERN_ELEVEN:
            begin
              next_st.addr_len = 3'd0;
              next_st.has_read = 1'b1;
            end
            PATTERN_TWELVE:
            begin
              next_st.has_op1 = 1'b1;
              next_st.has_write = 1'b1;
              next_st.has_read = 1'b0;
            end
            PATTERN_FIFTEEN:
            begin
              next_st.has_op2 = 1'b1;
              next_st.has_read = 1'b1;
            end
            PATTERN_TWENTY_TWO:
            begin
              next_st.addr_len = ADDR_QUEUE;
              next_st.addr_bytes = {second_address_register, first_address_register[15:0]};
              next_st.has_op2 = 1'b1;
              next_st.has_read = 1'b0;
            end
            PATTERN_TWENTY_THREE:
            begin
              next_st.addr_len = ADDR_ROW_ONLY;
              next_st.addr_bytes = {32'h00000000, first_address_register[39:16]};
              next_st.has_op1 = 1'b1;
              next_st.has_write = 1'b1;
              next_st.has_read = 1'b0;
            end
            default:
            begin
              next_st.has_read = 1'b0;
            end
          endcase
        end
      end
      NRS_OP0:
      begin
        issue_valid = 1'b1;
        issue_byte = st.op0;
        if (issue_ready)
        begin
          next_st.remain = st.count;
          next_st.state = (st.addr_len != 3'd0) ? NRS_ADDR
            : (st.has_read ? NRS_BUSY_WAIT : NRS_DONE);
        end
      end
      NRS_ADDR:
      begin
        issue_valid = 1'b1;
        issue_kind = NRS_CYC_ADDR;
        issue_byte = st.addr_bytes[7:0];
        if (issue_ready)
        begin
          next_st.addr_bytes = {8'h00, st.addr_bytes[55:8]};
          next_st.addr_idx = st.addr_idx + 3'd1;
          if (st.addr_idx + 3'd1 == st.addr_len)
          begin
            next_st.state = st.has_write ? NRS_WRITE : (st.has_op1 ? NRS_OP1
              : (st.has_op2 ? NRS_OP2 : NRS_DONE));
          end
        end
      end
      NRS_WRITE:
      begin
        // serial data starts at the addressed column
        issue_valid = wdata_valid && st.remain != 16'h0000;
        issue_kind = NRS_CYC_WDATA;
        issue_byte = wdata;
        wdata_ready = issue_ready && st.remain != 16'h0000;
        if (st.remain == 16'h0000)
        begin
          next_st.state = NRS_OP1;
        end
        else if (wdata_valid && issue_ready)
        begin
          next_st.remain = st.remain - 16'h0001;
        end
      end
      NRS_OP1:
      begin
        issue_valid = 1'b1;
        issue_byte = st.op1;
        if (issue_ready)
        begin
          next_st.state = st.has_op2 ? NRS_OP2 : NRS_DONE;
        end
      end
      NRS_OP2:
      begin
        // two-plane read repeats the address phase from the second register
        if (st.pattern == PATTERN_FIFTEEN && !st.second_addr)
        begin
          issue_valid = 1'b1;
          issue_byte = st.op2;
          if (issue_ready)
          begin
            next_st.second_addr = 1'b1;
            next_st.addr_idx = 3'd0;
            next_st.addr_bytes = {16'h0000, second_address_register};
            next_st.op2 = st.op1;
            next_st.has_op1 = 1'b0;
            next_st.state = NRS_ADDR;
          end
        end
        else
        begin
          issue_valid = 1'b1;
          issue_byte = st.op2;
          if (issue_ready)
          begin
            next_st.state = st.has_read ? NRS_BUSY_WAIT : NRS_DONE;
          end
        end
      end
      NRS_BUSY_WAIT:
      begin
        // closing opcode must leave the cycle unit first, or ready is still stale
        if (target_ready && !cyc_valid)
        begin
          next_st.state = NRS_READ;
          next_st.remain = st.to_data_reg ? 16'h0001 : st.count;
        end
      end
      NRS_READ:
      begin
        // one read in flight, so a stalled fifo never loses a byte
        issue_kind = NRS_CYC_RDATA;
        issue_valid = !st.rd_wait && st.remain != 16'h0000 && (st.to_data_reg || !st.fifo_full);
        if (issue_valid && issue_ready)
        begin
          next_st.rd_wait = 1'b1;
          next_st.remain = st.remain - 16'h0001;
        end
        if (rdata_valid && st.rd_wait)
        begin
          next_st.rd_wait = 1'b0;
          next_st.fifo_byte = st.to_data_reg ? st.fifo_byte : rdata;
          next_st.fifo_full = next_st.fifo_full || !st.to_data_reg;
          next_st.dreg = st.to_data_reg ? rdata : st.dreg;
        end
        else if (!st.rd_wait && st.remain == 16'h0000)
        begin
          next_st.state = NRS_DONE;
        end
      end
      NRS_DONE:
      begin
        if (!cyc_valid || cyc_ready)
        begin
          next_st.done = 1'b1;
          next_st.state = NRS_IDLE;
        end
      end
      default:
      begin
        next_st.state = NRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{state: NRS_IDLE, addr_bytes: 56'h0, count: LENGTH_RESET, remain: LENGTH_RESET, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  nrs_cycle_unit u_cycle (
    .core_clk(core_clk),
    .rstn(rstn),
    .issue_valid(issue_valid),
    .issue_ready(issue_ready),
    .issue_kind(issue_kind),
    .issue_byte(issue_byte),
    .cyc_valid(cyc_valid),
    .cyc_ready(cyc_ready),
    .cyc_kind(cyc_kind),
    .cyc_byte(cyc_byte)
  );

  assign start_ready = (st.state == NRS_IDLE) && target_ready;
  assign busy = st.state != NRS_IDLE;
  assign done = st.done;
  assign cmd_error = st.err;
  assign fifo_data = st.fifo_byte;
  assign fifo_valid = st.fifo_full;
  assign data_register = st.dreg;
endmodule
`default_nettype wire

/* File: tb/nrs_sequencer_sva.sv */
// port assertions for the nand command sequencer
// assumes one clock core_clk and asynchronous active-low rstn
`timescale 1ns/1ps
`default_nettype none
module nrs_sequencer_sva
  import nrs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic start_ready,
  input wire logic [4:0] sequence_pattern_field,
  input wire logic [7:0] opcode0,
  input wire logic target_ready,
  input wire logic done,
  input wire logic cmd_error,
  input wire logic cyc_valid,
  input wire logic cyc_ready,
  input wire nrs_pkg::nrs_cyc_t cyc_kind,
  input wire logic [7:0] cyc_byte,
  input wire logic [7:0] fifo_data,
  input wire logic fifo_valid,
  input wire logic fifo_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire legal = sequence_pattern_field inside {PATTERN_SEVEN, PATTERN_EIGHT, PATTERN_NINE, PATTERN_TEN,
    PATTERN_ELEVEN, PATTERN_TWELVE, PATTERN_FIFTEEN, PATTERN_TWENTY_TWO, PATTERN_TWENTY_THREE};
  sequence s_take;
    start && start_ready;
  endsequence
  sequence s_first_op;
    cyc_valid && cyc_kind == NRS_CYC_CMD && cyc_byte == opcode0;
  endsequence
  a_ready_gate: assert property (!target_ready |-> !start_ready)
    else $error("start offered to busy target");
  a_first_opcode: assert property (s_take ##0 legal |-> ##2 s_first_op)
    else $error("first opcode late or wrong");
  a_cycle_hold: assert property (cyc_valid && !cyc_ready |=> cyc_valid && $stable(cyc_byte) && $stable(cyc_kind))
    else $error("bus cycle changed while stalled");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_wait_busy: assert property (!target_ready && !cyc_valid |=> !cyc_valid)
    else $error("cycle issued while target busy");
  a_read_ready: assert property (cyc_valid && cyc_kind == NRS_CYC_RDATA |-> target_ready)
    else $error("read cycle while target busy");
  a_fifo_hold: assert property (fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data))
    else $error("fifo byte dropped while stalled");
  a_bad_pattern: assert property (s_take ##0 !legal |-> ##[1:4] (done && cmd_error))
    else $error("illegal pattern not flagged");
endmodule
bind nrs_sequencer nrs_sequencer_sva chk_u (.core_clk(core_clk), .rstn(rstn), .start(start),
  .start_ready(start_ready), .sequence_pattern_field(sequence_pattern_field), .opcode0(opcode0),
  .target_ready(target_ready), .done(done), .cmd_error(cmd_error), .cyc_valid(cyc_valid),
  .cyc_ready(cyc_ready), .cyc_kind(cyc_kind), .cyc_byte(cyc_byte), .fifo_data(fifo_data),
  .fifo_valid(fifo_valid), .fifo_ready(fifo_ready));
`default_nettype wire

/* File: tb/nrs_nand_model.sv */
// behavioural nand target: ready line, cycle acceptance, read bytes
// assumes the sequencer cycle handshake on core_clk
`timescale 1ns/1ps
`default_nettype none
module nrs_nand_model
  import nrs_pkg::*;
#(parameter int BUSY_CYC = 6)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic hold_busy,
  input wire logic cyc_valid,
  output logic cyc_ready,
  input wire nrs_pkg::nrs_cyc_t cyc_kind,
  input wire logic [7:0] cyc_byte,
  output logic target_ready,
  output logic [7:0] rdata,
  output logic rdata_valid
);
  int timer;
  logic [7:0] rd_idx;
  wire take = cyc_valid && cyc_ready;
  assign target_ready = timer == 0 && !hold_busy;
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      timer <= 0;
      cyc_ready <= 1'b0;
      rd_idx <= 8'h00;
      rdata <= 8'hFF;
      rdata_valid <= 1'b0;
    end
    else
    begin
      cyc_ready <= !slow || !cyc_ready;
      rdata_valid <= take && cyc_kind == NRS_CYC_RDATA;
      if (take && cyc_kind == NRS_CYC_RDATA)
      begin
        rdata <= 8'h50 + rd_idx;
        rd_idx <= rd_idx + 8'h01;
      end
      else
        rdata <= ~rdata;
      // busy after read, cache and program closing opcodes
      if (take && cyc_kind == NRS_CYC_CMD && cyc_byte inside {8'h30, 8'h10, 8'h31, 8'h3F})
        timer <= BUSY_CYC;
      else if (timer != 0)
        timer <= timer - 1;
    end
endmodule
`default_nettype wire

/* File: tb/nrs_sequencer_tb_top.sv */
// testbench of the nand command sequencer: instruction table, refusal, reset
// assumes nrs_pkg, nrs_sequencer, its checker and the nand model
`timescale 1ns/1ps
`default_nettype none
module nrs_sequencer_tb_top;
  import nrs_pkg::*;
  typedef struct {logic [4:0] pat; logic [7:0] op0, op1, op2; logic [39:0] a1, a2; logic [15:0] cnt, rd;} nrs_row_t;
  logic core_clk = 1'b0, rstn = 1'b0, start = 1'b0, slow = 1'b0, hold_busy = 1'b0, fifo_ready = 1'b1;
  logic [4:0] pat = 5'h00;
  logic dsel = 1'b0;
  logic [7:0] op0 = 8'h00, op1 = 8'h00, op2 = 8'h00, wdata = 8'hA0, cyc_byte, rdata, fifo_data, data_register;
  logic [39:0] a1 = 40'h0, a2 = 40'h0;
  logic [15:0] cnt = 16'h0;
  logic start_ready, busy, done, cmd_error, cyc_valid, cyc_ready, target_ready, rdata_valid, wdata_ready, fifo_valid;
  nrs_cyc_t cyc_kind;
  logic [9:0] log_q[$], exp_q[$];
  int errors = 0, samples_checked = 0, rd_cnt = 0, fifo_cnt = 0, cycles = 0;
  // table cases, the last one an illegal pattern: pattern, opcodes, addresses, byte count, reads (FFFF = not compared)
  nrs_row_t rows[12] = '{
    '{5'h07, 8'h06, 8'h00, 8'hE0, 40'h0504030201, 40'h0, 16'h0, 16'hFFFF},
    '{5'h08, 8'h85, 8'h00, 8'h00, 40'h000000BBAA, 40'h0, 16'h0, 16'hFFFF},
    '{5'h0C, 8'h85, 8'h11, 8'h00, 40'h1122334455, 40'h0, 16'h2, 16'hFFFF},
    '{5'h0A, 8'h00, 8'h00, 8'h30, 40'h0102030405, 40'h0, 16'h4, 16'h4},
    '{5'h0B, 8'h31, 8'h00, 8'h00, 40'h0, 40'h0, 16'h3, 16'h3},
    '{5'h0B, 8'h3F, 8'h00, 8'h00, 40'h0, 40'h0, 16'h3, 16'h3},
    '{5'h09, 8'h00, 8'h32, 8'h00, 40'h2122232425, 40'h0, 16'h0, 16'hFFFF},
    '{5'h16, 8'h07, 8'h00, 8'h37, 40'h0000000010, 40'h0A0B0C0D0E, 16'h0, 16'hFFFF},
    '{5'h0F, 8'h00, 8'h30, 8'h00, 40'h3132333435, 40'h1A1B1C1D1E, 16'h0, 16'hFFFF},
    '{5'h0C, 8'h80, 8'h10, 8'h00, 40'h4142434445, 40'h0, 16'h3, 16'hFFFF},
    '{5'h17, 8'h80, 8'h10, 8'h00, 40'h3300221100, 40'h0, 16'h2, 16'hFFFF},
    '{5'h01, 8'h80, 8'h10, 8'h00, 40'h0, 40'h0, 16'h1, 16'hFFFF}};
  nrs_sequencer dut_u (.core_clk(core_clk), .rstn(rstn), .start(start), .start_ready(start_ready),
    .sequence_pattern_field(pat), .opcode0(op0), .opcode1(op1), .opcode2(op2), .data_sel(dsel),
    .first_address_register(a1), .second_address_register(a2), .byte_count(cnt), .target_ready(target_ready),
    .busy(busy), .done(done), .cmd_error(cmd_error), .cyc_valid(cyc_valid), .cyc_ready(cyc_ready),
    .cyc_kind(cyc_kind), .cyc_byte(cyc_byte), .wdata(wdata), .wdata_valid(1'b1), .wdata_ready(wdata_ready),
    .rdata(rdata), .rdata_valid(rdata_valid), .fifo_data(fifo_data), .fifo_valid(fifo_valid),
    .fifo_ready(fifo_ready), .data_register(data_register));
  nrs_nand_model nand_u (.core_clk(core_clk), .rstn(rstn), .slow(slow), .hold_busy(hold_busy),
    .cyc_valid(cyc_valid), .cyc_ready(cyc_ready), .cyc_kind(cyc_kind), .cyc_byte(cyc_byte),
    .target_ready(target_ready), .rdata(rdata), .rdata_valid(rdata_valid));
  initial
    forever #2.5 core_clk = ~core_clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    fifo_ready <= !slow || !fifo_ready;
    if (cyc_valid && cyc_ready && cyc_kind != NRS_CYC_RDATA)
      log_q.push_back({cyc_kind, cyc_byte});
    if (cyc_valid && cyc_ready && cyc_kind == NRS_CYC_RDATA)
      rd_cnt++;
    if (wdata_ready)
      wdata <= wdata + 8'h01;
    if (fifo_valid && fifo_ready)
    begin
      chk("fifo_data", fifo_data, 8'h50 + fifo_cnt[7:0]);
      fifo_cnt++;
    end
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end
  task automatic put(input logic [1:0] k, input logic [7:0] b);
    exp_q.push_back({k, b});
  endtask
  task automatic addr(input logic [39:0] a, input int first, input int num);
    for (int i = first; i < first + num; i++)
      put(2'h1, a[8*i +: 8]);
  endtask
  task automatic wr(input logic [15:0] c);
    for (int i = 0; i < c; i++)
      put(2'h2, 8'hA0 + i[7:0]);
  endtask
  task automatic build(input nrs_row_t r);
    exp_q.delete();
    put(2'h0, r.op0);
    case (r.pat)
      5'h07, 5'h0A:
      begin
        addr(r.a1, 0, 5);
        put(2'h0, r.op2);
      end
      5'h08: addr(r.a1, 0, 2);
      5'h09:
      begin
        addr(r.a1, 0, 5);
        put(2'h0, r.op1);
      end
      5'h0B: ;
      5'h0C:
      begin
        addr(r.a1, 0, 5);
        wr(r.cnt);
        put(2'h0, r.op1);
      end
      5'h0F:
      begin
        addr(r.a1, 0, 5);
        put(2'h0, r.op2);
        addr(r.a2, 0, 5);
        put(2'h0, r.op1);
      end
      5'h16:
      begin
        addr(r.a1, 0, 2);
        addr(r.a2, 0, 5);
        put(2'h0, r.op2);
      end
      5'h17:
      begin
        addr(r.a1, 2, 3);
        wr(r.cnt);
        put(2'h0, r.op1);
      end
      default: exp_q.delete();
    endcase
  endtask
  task automatic run(input nrs_row_t r);
    int n;
    @(negedge core_clk);
    log_q.delete();
    rd_cnt = 0;
    build(r);
    @(posedge core_clk);
    {pat, op0, op1, op2, a1, a2, cnt} <= {r.pat, r.op0, r.op1, r.op2, r.a1, r.a2, r.cnt};
    wdata <= 8'hA0;
    start <= 1'b1;
    n = 0;
    do @(negedge core_clk); while (start_ready !== 1'b1 && ++n < 400);
    @(posedge core_clk);
    start <= 1'b0;
    n = 0;
    do @(negedge core_clk); while (done !== 1'b1 && ++n < 2000);
    chk("done", done, 1);
    chk("cmd_error", cmd_error, exp_q.size() == 0);
    chk("cycles", log_q.size(), exp_q.size());
    foreach (exp_q[i])
      chk("bus", log_q[i], exp_q[i]);
    if (r.rd != 16'hFFFF)
      chk("reads", rd_cnt, r.rd);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge core_clk);
      slow <= i[0];
      run(rows[i]);
    end
    // start held while the target is busy must wait
    @(posedge core_clk);
    hold_busy <= 1'b1;
    fork
      begin
        repeat (20) @(posedge core_clk);
        chk("early_cycles", log_q.size(), 0);
        hold_busy <= 1'b0;
      end
    join_none
    run(rows[3]);
    // reset in mid program
    @(posedge core_clk);
    {pat, op0, op1, cnt, start} <= {5'h0C, 8'h80, 8'h10, 16'h0040, 1'b1};
    repeat (12) @(posedge core_clk);
    rstn <= 1'b0;
    start <= 1'b0;
    @(negedge core_clk);
    chk("busy_rst", busy, 0);
    chk("valid_rst", cyc_valid, 0);
    chk("ready_rst", start_ready, target_ready);
    @(posedge core_clk);
    rstn <= 1'b1;
    run(rows[10]);
    // single byte into the data register, fifo left alone
    @(posedge core_clk);
    dsel <= 1'b1;
    run('{5'h0A, 8'h00, 8'h00, 8'h30, 40'h0102030405, 40'h0, 16'h4, 16'h1});
    chk("data_register", data_register, 8'h50);
    end_of_test();
  end
endmodule
`default_nettype wire
